// ==== rtl/analog_scan_adapter.sv ====
// Purpose: computer-side adapter: word decode, slow/fast selection,
//          conversion sequencing, comparators, test time and relays.
// Assumes: computer holds the word with valid until ready; comparator
//          levels arrive already routed per cmp_sel_out.
// Notes:   odd parity on the word; external targets echo their address.
`timescale 1ns/1ns
module analog_scan_adapter #(
  parameter int CONV_PERIOD = analog_scan_pkg::CONV_PERIOD_CYC
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic cmd_valid_in,
  input wire logic [analog_scan_pkg::WORD_W-1:0] cmd_word_in,
  output logic cmd_ready_out,
  output analog_scan_pkg::slot_map_t slow_sel_out,
  output logic [analog_scan_pkg::CH_W-1:0] scan_ch_out,
  output logic scan_auto_out,
  output logic low_amp_en_out,
  output logic [analog_scan_pkg::CMP_W-1:0] low_amp_sel_out,
  output logic adc_start_out,
  input wire logic adc_done_in,
  input wire logic [analog_scan_pkg::SMP_W-1:0] adc_data_in,
  output analog_scan_pkg::cmp_src_t cmp_sel_out,
  input wire logic [analog_scan_pkg::N_CMP-1:0] cmp_level_in,
  output logic [analog_scan_pkg::N_CMP-1:0] cmp_irq_out,
  input wire logic sec_pulse_in,
  output logic [analog_scan_pkg::TIME_W-1:0] test_time_out,
  output logic [analog_scan_pkg::RELAY_W-1:0] relay_out,
  output analog_scan_pkg::ext_req_t ext_req_out,
  output logic ext_strobe_out,
  input wire logic ext_ack_in,
  input wire logic [analog_scan_pkg::ADDR_W:0] ext_echo_in,
  input wire logic [analog_scan_pkg::WORD_W-1:0] ext_rdata_in,
  output logic [analog_scan_pkg::WORD_W-1:0] rd_data_out,
  output logic rd_valid_out,
  output logic [analog_scan_pkg::ERR_W-1:0] err_out
);
  import analog_scan_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n;
  core_state_t q, d;
  logic take;
  logic [PAY_W-1:0] pay;
  logic [ADDR_W-1:0] addr;
  logic [SLOT_W-1:0] slot_idx;
  logic [POOL_W-1:0] pool_idx;
  logic [CMP_W-1:0] cmp_idx;
  logic [CH_W-1:0] cmp_ch;
  logic [N_CMP-1:0] hit;
  logic [N_CMP-1:0] clr;
  logic [CH_W-1:0] low_off;
  sample_t smp;
  logic smp_valid;

  // release of the async reset is retimed so every flop leaves reset together
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  conv_pacer #(
    .PERIOD(CONV_PERIOD)
  ) u_pacer (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .ch_in(q.ch),
    .adc_done_in(adc_done_in),
    .adc_data_in(adc_data_in),
    .adc_start_out(adc_start_out),
    .sample_out(smp),
    .sample_valid_out(smp_valid)
  );

  // the computer owns the exchange; one word at a time, whole words only
  assign take = cmd_valid_in && cmd_ready_out;
  assign pay = payload(cmd_word_in);
  assign addr = cmd_word_in[ADDR_W-1:0];
  assign slot_idx = pay[SLOT_LSB +: SLOT_W];
  assign pool_idx = pay[POOL_LSB +: POOL_W];
  assign cmp_idx = pay[CMP_W-1:0];
  assign cmp_ch = pay[CMP_SRC_LSB +: CH_W];
  assign hit = cmp_level_in ^ q.cmp_prev;
  assign low_off = q.ch - LOW_BASE;

  always_comb begin
    d = q;
    clr = '0;
    d.ext_strobe = 1'b0;
    d.rvalid = 1'b0;
    d.irq = '0;
    d.cmp_prev = cmp_level_in;
    if (sec_pulse_in) begin
      d.ttime = q.ttime + 1'b1;
    end
    if (smp_valid) begin
      d.last = smp;
      if (q.auto_scan) begin
        d.ch = (q.ch == CH_LAST) ? '0 : q.ch + 1'b1;
      end
    end
    case (q.st)
      ST_IDLE: begin
        if (take) begin
          if (!par_ok(cmd_word_in)) begin
            d.err[E_PAR] = 1'b1;
          end else if (cmd_word_in[EXT_BIT]) begin
            d.ext.instr = cmd_word_in[INSTR_BIT];
            d.ext.addr = addr;
            d.ext.data = pay;
            d.ext_strobe = 1'b1;
            d.wait_cnt = '0;
            d.st = ST_SEND;
          end else if (cmd_word_in[INSTR_BIT]) begin
            case (addr)
              A_SLOW_SEL: begin
                if (slot_idx < N_SLOT && pool_idx < N_POOL) begin
                  d.slot[slot_idx] = pool_idx;
                end else begin
                  d.err[E_RANGE] = 1'b1;
                end
              end
              A_SCAN_MODE: begin
                d.auto_scan = pay[0];
              end
              A_SCAN_STEP: begin
                if (pay[CH_W-1:0] < N_CH) begin
                  d.ch = pay[CH_W-1:0];
                end else begin
                  d.err[E_RANGE] = 1'b1;
                end
              end
              A_CMP_SRC: begin
                if (cmp_idx < N_CMP_IDX && cmp_ch < N_CH) begin
                  d.cmp_src[cmp_idx] = cmp_ch;
                  d.cmp_irq_mode[cmp_idx] = pay[CMP_MODE_BIT];
                end else begin
                  d.err[E_RANGE] = 1'b1;
                end
              end
              A_TIME_LOAD: begin
                d.ttime = pay[TIME_W-1:0];
              end
              A_RELAY: begin
                d.relay = pay[RELAY_W-1:0];
              end
              default: begin
                d.err[E_RANGE] = 1'b1;
              end
            endcase
          end else begin
            d.rvalid = 1'b1;
            case (addr)
              R_SAMPLE: begin
                d.rdata = {6'h00, q.last};
              end
              R_CMP: begin
                if (cmp_idx < N_CMP_IDX) begin
                  d.rdata = {q.held[cmp_idx], 6'h00, q.cap[cmp_idx]};
                  clr[cmp_idx] = 1'b1;
                end else begin
                  d.rdata = '0;
                  d.err[E_RANGE] = 1'b1;
                end
              end
              R_TIME: begin
                d.rdata = {7'h00, q.ttime};
              end
              R_STATUS: begin
                d.rdata = {20'h00000, q.err};
                d.err = '0;
              end
              R_LOOP: begin
                // echoes the payload so software can prove the path end to end
                d.rdata = {7'h00, pay};
              end
              default: begin
                d.rdata = '0;
                d.err[E_RANGE] = 1'b1;
              end
            endcase
          end
        end
      end
      ST_SEND: begin
        d.st = ST_WAIT;
      end
      ST_WAIT: begin
        d.wait_cnt = q.wait_cnt + 1'b1;
        if (ext_ack_in) begin
          d.st = ST_IDLE;
          if (ext_echo_in != {q.ext.instr, q.ext.addr}) begin
            d.err[E_ROUTE] = 1'b1;
          end else if (!q.ext.instr) begin
            d.rdata = ext_rdata_in;
            d.rvalid = 1'b1;
          end
        end else if (q.wait_cnt == EXT_TIMEOUT) begin
          // a dead console must not hang the exchange path
          d.err[E_ROUTE] = 1'b1;
          d.st = ST_IDLE;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    // a read and a fresh edge in one cycle: the new capture wins
    for (int i = 0; i < N_CMP; i++) begin
      d.held[i] = q.held[i] & ~clr[i];
      if (q.cmp_irq_mode[i]) begin
        d.irq[i] = hit[i];
      end else if (hit[i]) begin
        if (!q.held[i] || clr[i]) begin
          d.held[i] = 1'b1;
          d.cap[i] = q.ttime;
        end else begin
          d.err[E_LOST] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  assign cmd_ready_out = (q.st == ST_IDLE);
  assign slow_sel_out = q.slot;
  assign scan_ch_out = q.ch;
  assign scan_auto_out = q.auto_scan;
  // slots 24 to 29 are the low-level group sharing the six amplifiers
  assign low_amp_en_out = (q.ch >= LOW_BASE) && (q.ch < LOW_END);
  assign low_amp_sel_out = low_amp_en_out ? low_off[CMP_W-1:0] : '0;
  assign cmp_sel_out = q.cmp_src;
  assign cmp_irq_out = q.irq;
  assign test_time_out = q.ttime;
  assign relay_out = q.relay;
  assign ext_req_out = q.ext;
  assign ext_strobe_out = q.ext_strobe;
  assign rd_data_out = q.rdata;
  assign rd_valid_out = q.rvalid;
  assign err_out = q.err;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n);

  logic good_int;
  assign good_int = take && par_ok(cmd_word_in) && !cmd_word_in[EXT_BIT]
    && cmd_word_in[INSTR_BIT];

  a_slow_load: assert property (good_int && addr == A_SLOW_SEL
    && slot_idx < N_SLOT && pool_idx < N_POOL
    |=> q.slot[$past(slot_idx)] == $past(pool_idx))
    else $error("slow selection slot not loaded");
  a_low_amp: assert property ((q.ch == LOW_BASE |-> low_amp_en_out
    && low_amp_sel_out == 3'h0) and (q.ch < LOW_BASE |-> !low_amp_en_out))
    else $error("low-level amplifier mapping wrong");
  a_auto_step: assert property (q.auto_scan && smp_valid
    && q.ch < CH_LAST && !take |=> q.ch == $past(q.ch) + 6'h01)
    else $error("automatic scan did not advance");
  a_auto_wrap: assert property (q.auto_scan && smp_valid
    && q.ch == CH_LAST && !take |=> q.ch == 6'h00)
    else $error("automatic scan did not wrap");
  a_cmp_route: assert property (good_int && addr == A_CMP_SRC
    && cmp_idx < N_CMP_IDX && cmp_ch < N_CH
    |=> cmp_sel_out[$past(cmp_idx)] == $past(cmp_ch))
    else $error("comparator source not routed");
  a_cmp_capture: assert property (hit[0] && !q.cmp_irq_mode[0]
    && !q.held[0] |=> q.held[0] && q.cap[0] == $past(q.ttime))
    else $error("comparator edge did not capture time");
  a_cmp_irq: assert property (hit[0] && q.cmp_irq_mode[0]
    |=> cmp_irq_out[0] ##1 !cmp_irq_out[0] || $past(hit[0]))
    else $error("comparator interrupt not raised");
  a_cap_hold: assert property (q.held[0] && !clr[0]
    |=> q.held[0] && $stable(q.cap[0]))
    else $error("unread capture overwritten");
  a_ext_route: assert property (take && par_ok(cmd_word_in)
    && cmd_word_in[EXT_BIT] |=> ext_strobe_out && !cmd_ready_out
    ##1 !ext_strobe_out)
    else $error("external word not delivered");
  a_int_stay: assert property (take && !cmd_word_in[EXT_BIT]
    |=> !ext_strobe_out && cmd_ready_out)
    else $error("internal word leaked outside");
  a_parity_drop: assert property (take && !par_ok(cmd_word_in)
    |=> err_out[E_PAR] && !ext_strobe_out && !rd_valid_out)
    else $error("bad parity word was acted on");
  a_echo_check: assert property (q.st == ST_WAIT && ext_ack_in
    && ext_echo_in != {q.ext.instr, q.ext.addr}
    |=> err_out[E_ROUTE] && !rd_valid_out)
    else $error("echo mismatch not flagged");
  a_relay_set: assert property (good_int && addr == A_RELAY
    |=> relay_out == $past(pay[RELAY_W-1:0]))
    else $error("relays not driven");
  a_time_tick: assert property (sec_pulse_in
    && !(good_int && addr == A_TIME_LOAD)
    |=> test_time_out == $past(test_time_out) + 17'h00001)
    else $error("test time did not advance");

  c_auto_wrap: cover property (q.auto_scan && smp_valid && q.ch == CH_LAST);
  c_capture: cover property (hit[0] && !q.cmp_irq_mode[0] ##[1:20] clr[0]);
  c_ext_read: cover property (ext_strobe_out ##[1:20] rd_valid_out);
  c_irq: cover property (cmp_irq_out != '0);
endmodule

// ==== rtl/analog_scan_pkg.sv ====
// Purpose: shared constants, field layouts and carrier types for the
//          computer-side analog scan adapter.
// Assumes: one 125 MHz clock; all external inputs except arst_n_in synchronous to it.
// Notes:   word bit n of the printed numbering is cmd_word bit n-1.
// Functional notes
// - slow stage picks 30 three-wire inputs out of 300 as the computer sets.
// - six of the 30 slots carry low-level inputs sharing six amplifiers.
// - fast stage covers 30 selected plus 20 fixed inputs, auto or stepped.
// - each scanned value becomes a 12-bit word, at most 5000 per second.
// - six comparators, each routable to any of the 50 fast-stage inputs.
// - a comparator edge either captures the time value or interrupts.
// - word bit 6 chooses internal or external, bit 5 instruction or read; bits 1 to 4 are the address.
// - exchanges are self-checked so a word at a wrong destination is flagged.
// - an internal address drives the adapter's own relays for consoles.
// - test time counter loads a start value, then counts each second pulse.
package analog_scan_pkg;
  localparam int WORD_W = 24;
  localparam int PAY_W = 17;
  localparam int PAY_LSB = 6;
  localparam int PAR_BIT = 23;
  localparam int EXT_BIT = 5;
  localparam int INSTR_BIT = 4;
  localparam int ADDR_W = 4;
  localparam int N_SEL = 30;
  localparam int POOL_W = 9;
  localparam int SLOT_W = 5;
  localparam int CH_W = 6;
  localparam int N_CMP = 6;
  localparam int CMP_W = 3;
  localparam int SMP_W = 12;
  localparam int TIME_W = 17;
  localparam int RELAY_W = 16;
  localparam int ERR_W = 4;
  localparam int WAIT_W = 8;
  localparam int CONV_CNT_W = 15;
  localparam logic [POOL_W-1:0] N_POOL = 9'h12c;
  localparam logic [SLOT_W-1:0] N_SLOT = 5'h1e;
  localparam logic [CH_W-1:0] N_CH = 6'h32;
  localparam logic [CH_W-1:0] CH_LAST = 6'h31;
  localparam logic [CH_W-1:0] LOW_BASE = 6'h18;
  localparam logic [CH_W-1:0] LOW_END = 6'h1e;
  localparam logic [CMP_W-1:0] N_CMP_IDX = 3'h6;
  localparam logic [WAIT_W-1:0] EXT_TIMEOUT = 8'hff;
  // payload field positions
  localparam int SLOT_LSB = 0;
  localparam int POOL_LSB = 5;
  localparam int CMP_SRC_LSB = 3;
  localparam int CMP_MODE_BIT = 9;
  // internal instruction addresses
  localparam logic [ADDR_W-1:0] A_SLOW_SEL = 4'h0;
  localparam logic [ADDR_W-1:0] A_SCAN_MODE = 4'h1;
  localparam logic [ADDR_W-1:0] A_SCAN_STEP = 4'h2;
  localparam logic [ADDR_W-1:0] A_CMP_SRC = 4'h3;
  localparam logic [ADDR_W-1:0] A_TIME_LOAD = 4'h4;
  localparam logic [ADDR_W-1:0] A_RELAY = 4'h5;
  // internal read-in addresses
  localparam logic [ADDR_W-1:0] R_SAMPLE = 4'h0;
  localparam logic [ADDR_W-1:0] R_CMP = 4'h1;
  localparam logic [ADDR_W-1:0] R_TIME = 4'h2;
  localparam logic [ADDR_W-1:0] R_STATUS = 4'h3;
  localparam logic [ADDR_W-1:0] R_LOOP = 4'h4;
  // conversion pacing
  localparam longint CLK_HZ = 125000000;
  localparam longint CONV_RATE_HZ = 5000;
  localparam int CONV_PERIOD_CYC =
    int'((CLK_HZ + CONV_RATE_HZ - 1) / CONV_RATE_HZ);

  typedef logic [N_SEL-1:0][POOL_W-1:0] slot_map_t;
  typedef logic [N_CMP-1:0][CH_W-1:0] cmp_src_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b11
  } xfer_state_t;
  typedef struct packed {
    logic instr;
    logic [ADDR_W-1:0] addr;
    logic [PAY_W-1:0] data;
  } ext_req_t;
  typedef struct packed {
    logic [CH_W-1:0] ch;
    logic [SMP_W-1:0] data;
  } sample_t;
  typedef struct packed {
    logic [CONV_CNT_W-1:0] cnt;
    logic busy;
    logic start;
    sample_t smp;
    logic valid;
  } pacer_state_t;
  typedef struct packed {
    xfer_state_t st;
    logic [WAIT_W-1:0] wait_cnt;
    slot_map_t slot;
    logic auto_scan;
    logic [CH_W-1:0] ch;
    cmp_src_t cmp_src;
    logic [N_CMP-1:0] cmp_irq_mode;
    logic [N_CMP-1:0] cmp_prev;
    logic [N_CMP-1:0] held;
    logic [N_CMP-1:0][TIME_W-1:0] cap;
    logic [N_CMP-1:0] irq;
    logic [TIME_W-1:0] ttime;
    logic [RELAY_W-1:0] relay;
    sample_t last;
    ext_req_t ext;
    logic ext_strobe;
    logic [WORD_W-1:0] rdata;
    logic rvalid;
    logic [ERR_W-1:0] err;
  } core_state_t;
  localparam core_state_t CORE_RST = '0;
  localparam pacer_state_t PACER_RST = '0;
  // error bits
  localparam int E_PAR = 0;
  localparam int E_ROUTE = 1;
  localparam int E_RANGE = 2;
  localparam int E_LOST = 3;

  // odd parity over the whole word, bit 24 being the check bit
  function automatic logic par_ok(input logic [WORD_W-1:0] w);
    return ^w;
  endfunction
  function automatic logic [PAY_W-1:0] payload(input logic [WORD_W-1:0] w);
    return w[PAR_BIT-1:PAY_LSB];
  endfunction
endpackage

// ==== rtl/conv_pacer.sv ====
// Purpose: paces converter starts and captures each 12-bit result.
// Assumes: converter raises done for one cycle per started conversion.
// Notes:   a slow converter only delays the next start, never crowds it.
`timescale 1ns/1ns
module conv_pacer #(
  parameter int PERIOD = analog_scan_pkg::CONV_PERIOD_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [analog_scan_pkg::CH_W-1:0] ch_in,
  input wire logic adc_done_in,
  input wire logic [analog_scan_pkg::SMP_W-1:0] adc_data_in,
  output logic adc_start_out,
  output analog_scan_pkg::sample_t sample_out,
  output logic sample_valid_out
);
  import analog_scan_pkg::*;
  localparam logic [CONV_CNT_W-1:0] RELOAD = CONV_CNT_W'(PERIOD - 1);
  pacer_state_t q, d;

  always_comb begin
    d = q;
    d.start = 1'b0;
    d.valid = 1'b0;
    if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
    end
    if (q.cnt == '0 && !q.busy) begin
      d.start = 1'b1;
      d.busy = 1'b1;
      d.cnt = RELOAD;
      d.smp.ch = ch_in;
    end
    if (q.busy && adc_done_in) begin
      d.busy = 1'b0;
      d.smp.data = adc_data_in;
      d.valid = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= PACER_RST;
    end else begin
      q <= d;
    end
  end

  assign adc_start_out = q.start;
  assign sample_out = q.smp;
  assign sample_valid_out = q.valid;

  logic [CONV_CNT_W-1:0] gap_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap_q <= '1;
    end else if (q.start) begin
      gap_q <= '0;
    end else if (gap_q != '1) begin
      gap_q <= gap_q + 1'b1;
    end
  end
  a_start_spacing: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    q.start |-> gap_q >= RELOAD)
    else $error("conversions started faster than the rate limit");
  a_sample_taken: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    q.busy && adc_done_in |=> q.valid && q.smp.data == $past(adc_data_in))
    else $error("converter result not captured");
endmodule

// ==== verif/far_side_model.sv ====
// Purpose: converter and external target on the adapter's far side.
// Assumes: start and strobe are one-cycle pulses from the adapter.
// Notes:   released data lines show the inverse of their last value.
`timescale 1ns/1ns
module far_side_model (
  input wire logic clk_in,
  input wire logic adc_start_in,
  input wire logic [analog_scan_pkg::CH_W-1:0] ch_in,
  output logic adc_done_out,
  output logic [analog_scan_pkg::SMP_W-1:0] adc_data_out,
  input wire logic ext_strobe_in,
  input wire analog_scan_pkg::ext_req_t ext_req_in,
  input wire logic slow_in,
  input wire logic bad_echo_in,
  output logic ext_ack_out,
  output logic [analog_scan_pkg::ADDR_W:0] ext_echo_out,
  output logic [analog_scan_pkg::WORD_W-1:0] ext_rdata_out
);
  import analog_scan_pkg::*;
  int adc_cnt = 0;
  int ext_cnt = 0;
  logic [CH_W-1:0] ch_q = '0;
  ext_req_t req_q = '0;
  initial begin
    adc_done_out = 1'b0;
    adc_data_out = '0;
    ext_ack_out = 1'b0;
    ext_echo_out = '0;
    ext_rdata_out = '0;
  end
  always @(posedge clk_in) begin
    adc_done_out <= 1'b0;
    ext_ack_out <= 1'b0;
    if (adc_done_out) adc_data_out <= ~adc_data_out;
    if (ext_ack_out) begin
      ext_echo_out <= ~ext_echo_out;
      ext_rdata_out <= ~ext_rdata_out;
    end
    if (adc_start_in) begin
      ch_q <= ch_in;
      adc_cnt <= 3;
    end else if (adc_cnt > 1) begin
      adc_cnt <= adc_cnt - 1;
    end else if (adc_cnt == 1) begin
      adc_cnt <= 0;
      adc_done_out <= 1'b1;
      adc_data_out <= {6'h3c, ch_q};
    end
    if (ext_strobe_in) begin
      req_q <= ext_req_in; // setting held until the later ack
      ext_cnt <= slow_in ? 6 : 1;
    end else if (ext_cnt > 1) begin
      ext_cnt <= ext_cnt - 1;
    end else if (ext_cnt == 1) begin
      ext_cnt <= 0;
      ext_ack_out <= 1'b1;
      // a wrong echo is only sent when the bench asks for it
      ext_echo_out <= {req_q.instr, req_q.addr} ^ {4'h0, bad_echo_in};
      ext_rdata_out <= {2'h1, req_q};
    end
  end
endmodule

// ==== verif/tb_analog_scan_adapter.sv ====
// Purpose: self-checking bench for the analog scan adapter.
// Assumes: far_side_model plays converter and external target.
// Notes:   short conversion period keeps the run brief.
`timescale 1ns/1ns
module tb_analog_scan_adapter;
  import analog_scan_pkg::*;
  localparam int PER = 20;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic vld = 1'b0;
  logic [WORD_W-1:0] word = '0;
  logic [N_CMP-1:0] lvl = '0;
  logic sec = 1'b0;
  logic bad = 1'b0;
  logic slow = 1'b0;
  logic rdy, auto, amp_en, start, done, strobe, ack, rvld;
  slot_map_t ssel;
  cmp_src_t csel;
  ext_req_t req;
  logic [CH_W-1:0] ch;
  logic [CMP_W-1:0] amp_sel;
  logic [SMP_W-1:0] adata;
  logic [N_CMP-1:0] irq;
  logic [TIME_W-1:0] ttime;
  logic [RELAY_W-1:0] relay;
  logic [ADDR_W:0] echo;
  logic [WORD_W-1:0] xdata, rdata;
  logic [ERR_W-1:0] err;
  int fail_count = 0;
  int n_compared = 0;
  analog_scan_adapter #(.CONV_PERIOD(PER)) dut_u (
    .clk_in(clk), .arst_n_in(arst_n), .cmd_valid_in(vld),
    .cmd_word_in(word), .cmd_ready_out(rdy), .slow_sel_out(ssel),
    .scan_ch_out(ch), .scan_auto_out(auto), .low_amp_en_out(amp_en),
    .low_amp_sel_out(amp_sel), .adc_start_out(start),
    .adc_done_in(done), .adc_data_in(adata), .cmp_sel_out(csel),
    .cmp_level_in(lvl), .cmp_irq_out(irq), .sec_pulse_in(sec),
    .test_time_out(ttime), .relay_out(relay), .ext_req_out(req),
    .ext_strobe_out(strobe), .ext_ack_in(ack), .ext_echo_in(echo),
    .ext_rdata_in(xdata), .rd_data_out(rdata), .rd_valid_out(rvld),
    .err_out(err));
  far_side_model far_u (
    .clk_in(clk), .adc_start_in(start), .ch_in(ch),
    .adc_done_out(done), .adc_data_out(adata),
    .ext_strobe_in(strobe), .ext_req_in(req), .slow_in(slow),
    .bad_echo_in(bad), .ext_ack_out(ack), .ext_echo_out(echo),
    .ext_rdata_out(xdata));
  always #4 clk = ~clk;
  task automatic close_out;
    if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] s, e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [23:0] mk(input logic x, i,
      input logic [3:0] a, input logic [16:0] p);
    logic [22:0] w;
    w = {p, x, i, a};
    return {~^w, w};
  endfunction
  // word stays up until the edge that sees ready, then drops
  task automatic send(input logic [23:0] w);
    logic c;
    @(posedge clk);
    #1;
    vld = 1'b1;
    word = w;
    for (int i = 0; i < 300; i++) begin
      c = rdy;
      @(posedge clk);
      if (c === 1'b1) begin
        #1;
        vld = 1'b0;
        return;
      end
    end
    fail_count++;
    close_out;
  endtask
  task automatic ins(input logic [3:0] a, input logic [16:0] p);
    send(mk(1'b0, 1'b1, a, p));
    tick(1);
  endtask
  task automatic rd(input logic [3:0] a, input logic [16:0] p,
      output logic [23:0] d);
    send(mk(1'b0, 1'b0, a, p));
    chk("rd_valid", 24'(rvld), 24'h1);
    d = rdata;
  endtask
  task automatic status(input logic [3:0] e);
    logic [23:0] d;
    rd(R_STATUS, '0, d);
    chk("status", d, 24'(e));
    chk("err_clear", 24'(err), 24'h0);
  endtask
  task automatic t_relay_time;
    logic [23:0] d;
    ins(A_RELAY, 17'h0beef);
    chk("relay", 24'(relay), 24'h00beef);
    send(mk(1'b0, 1'b1, A_RELAY, 17'h00001) ^ 24'h800000);
    tick(1);
    chk("relay_kept", 24'(relay), 24'h00beef);
    status(4'h1);
    ins(A_TIME_LOAD, 17'h1fffe);
    chk("time_load", 24'(ttime), 24'h01fffe);
    sec = 1'b1;
    tick(1);
    sec = 1'b0;
    chk("time_tick", 24'(ttime), 24'h01ffff);
    rd(R_TIME, '0, d);
    chk("time_read", d, 24'h01ffff);
    rd(R_LOOP, 17'h1a5a5, d);
    chk("loop", d, 24'h01a5a5);
  endtask
  task automatic t_select;
    ins(A_SLOW_SEL, {3'h0, 9'h12b, 5'h1d});
    chk("slow_sel", 24'(ssel[29]), 24'h00012b);
    ins(A_SLOW_SEL, {3'h0, 9'h12c, 5'h00});
    chk("pool_range", 24'(ssel[0]), 24'h0);
    status(4'h4);
    ins(A_SCAN_STEP, 17'h00018);
    chk("amp_base", 24'({amp_en, amp_sel}), 24'h8);
    ins(A_SCAN_STEP, 17'h00019);
    chk("step", 24'(ch), 24'h19);
    chk("amp", 24'({amp_en, amp_sel}), 24'h9);
    ins(A_SCAN_STEP, 17'h0001e);
    chk("amp_off", 24'(amp_en), 24'h0);
    ins(A_SCAN_STEP, 17'h00032);
    chk("ch_range", 24'(ch), 24'h1e);
    status(4'h4);
  endtask
  task automatic t_scan;
    logic [23:0] d;
    int n;
    ins(A_SCAN_STEP, 17'h00031);
    tick(2 * PER + 10);
    ins(A_SCAN_MODE, 17'h00001);
    chk("auto", 24'(auto), 24'h1);
    for (n = 0; n < 3 * PER && ch !== '0; n++) tick(1);
    chk("wrap", 24'(ch), 24'h0);
    rd(R_SAMPLE, '0, d);
    chk("sample", d, {6'h0, 6'h31, 6'h3c, 6'h31});
    for (n = 0; n < 3 * PER && start !== 1'b1; n++) tick(1);
    tick(1);
    for (n = 1; n < 3 * PER && start !== 1'b1; n++) tick(1);
    chk("spacing", 24'(n), 24'(PER));
    ins(A_SCAN_MODE, 17'h00000);
    d = 24'(ch);
    tick(3 * PER);
    chk("stepped", 24'(ch), d);
  endtask
  task automatic t_cmp;
    logic [23:0] d;
    ins(A_TIME_LOAD, 17'h00100);
    ins(A_CMP_SRC, {7'h0, 1'b0, 6'h07, 3'h0});
    chk("cmp_sel0", 24'(csel[0]), 24'h07);
    ins(A_CMP_SRC, {7'h0, 1'b1, 6'h31, 3'h1});
    chk("cmp_sel1", 24'(csel[1]), 24'h31);
    lvl[1] = 1'b1;
    tick(1);
    chk("irq", 24'(irq), 24'h02);
    tick(1);
    chk("irq_end", 24'(irq), 24'h0);
    lvl[0] = 1'b1;
    tick(2);
    ins(A_TIME_LOAD, 17'h00200);
    lvl[0] = 1'b0;
    tick(2);
    chk("lost", 24'(err), 24'h8);
    rd(R_CMP, 17'h0, d);
    chk("cap", d, {1'b1, 6'h0, 17'h00100});
    rd(R_CMP, 17'h0, d);
    chk("held_clr", 24'(d[23]), 24'h0);
    status(4'h8);
  endtask
  task automatic t_ext;
    int n;
    send(mk(1'b1, 1'b0, 4'h3, 17'h0abcd));
    chk("strobe", 24'(strobe), 24'h1);
    chk("req", 24'(req), {2'h0, 1'b0, 4'h3, 17'h0abcd});
    chk("busy", 24'(rdy), 24'h0);
    for (n = 0; n < 40 && rvld !== 1'b1; n++) tick(1);
    chk("ext_rd", rdata, {2'h1, 1'b0, 4'h3, 17'h0abcd});
    bad = 1'b1;
    slow = 1'b1;
    send(mk(1'b1, 1'b1, 4'h7, 17'h00001));
    for (n = 0; n < 40 && err !== 4'h2; n++) tick(1);
    chk("echo_err", 24'(err), 24'h2);
    bad = 1'b0;
    status(4'h2);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1;
    chk("rst_ready", 24'(rdy), 24'h1);
    chk("rst_relay", 24'(relay), 24'h0);
    arst_n = 1'b1;
    tick(2);
    t_relay_time();
    t_select();
    t_scan();
    t_cmp();
    t_ext();
    close_out();
  end
endmodule
